/* core/fpse_top.v */
// status, interrupt enable and program/erase mode entry of the flash sequencer
//
// Function
// - violation flag clears by 0 after read 1
// - command lock raises access error when enabled
// - access violation raises access error when enabled
// - program suspended from suspend start to resume
// - erase suspended from suspend start to resume
// - suspend ready set, cleared by suspend/lock
// - program error sets, locks, cleared by clear
// - erase error sets, locks, cleared by clear
// - illegal error locks, clears only at 10h
// - ready low while busy, reset value one
// - chip reset initialises these registers, soft reset all but the interrupt enables
// - lock status holds last read-two lock bit
// - internal error sets; software then soft resets
// - ready rising edge raises ready interrupt
// - entry writes need key, key not kept
// - keyed entry writes only while ready
// - code entry sets only from all zero
// - byte, bad key or zero clears entry
// - keyed write when nonzero clears entry
// - both entry bits set is illegal, locks
// - entry bit selects read or program window
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "fpse_defines.vh"

module fpse_top (
  input wire clk_sys_i,
  input wire rst_b_i,
  // register port
  input wire [23:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_word_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // sequencer events and levels
  input wire seq_soft_reset_i,
  input wire seq_busy_i,
  input wire prog_suspend_start_i,
  input wire erase_suspend_start_i,
  input wire resume_accept_i,
  input wire suspend_point_i,
  input wire suspend_accept_i,
  input wire prog_fail_i,
  input wire prog_locked_area_i,
  input wire erase_fail_i,
  input wire erase_locked_area_i,
  input wire illegal_cmd_i,
  input wire status_clear_cmd_i,
  input wire code_violation_i,
  input wire [2:0] data_violation_i,
  input wire lock_read_done_i,
  input wire lock_bit_i,
  input wire internal_error_i,
  // outputs
  output reg access_error_irq_o,
  output reg ready_irq_o,
  output reg cmd_accept_ok_o,
  output reg code_pe_entry_o,
  output reg data_pe_entry_o,
  output reg [31:0] code_window_base_o
);

  // address hits
  wire hit_acc;
  wire hit_aie;
  wire hit_rie;
  wire hit_s0;
  wire hit_s1;
  wire hit_ent;
  assign hit_acc = (reg_addr_i == `FPSE_OFF_ACC_STAT);
  assign hit_aie = (reg_addr_i == `FPSE_OFF_ACC_ERR_IE);
  assign hit_rie = (reg_addr_i == `FPSE_OFF_RDY_IE);
  assign hit_s0 = (reg_addr_i == `FPSE_OFF_STAT0);
  assign hit_s1 = (reg_addr_i == `FPSE_OFF_STAT1);
  assign hit_ent = (reg_addr_i == `FPSE_OFF_ENTRY);

  // stored state
  reg [7:0] acc_err_ie_r;
  reg [7:0] rdy_ie_r;
  reg ready_r;
  reg lock_status_r;
  reg cav_armed_r;
  reg [15:0] entry_r;
  reg [15:0] entry_nxt;

  // flag vectors
  reg [`FPSE_NFLAG-1:0] flag_set;
  reg [`FPSE_NFLAG-1:0] flag_clr;
  wire [`FPSE_NFLAG-1:0] flag_q;

  // views of individual flags
  wire prg_spd;
  wire ers_spd;
  wire sus_rdy;
  wire prg_err;
  wire ers_err;
  wire ilgl_err;
  wire seq_err;
  wire cmd_lk;
  wire cav;
  assign prg_spd = flag_q[`FPSE_F_PROGRAM_SUSPENDED];
  assign ers_spd = flag_q[`FPSE_F_ERASE_SUSPENDED];
  assign sus_rdy = flag_q[`FPSE_F_SUSPEND_READY];
  assign prg_err = flag_q[`FPSE_F_PROGRAM_ERROR];
  assign ers_err = flag_q[`FPSE_F_ERASE_ERROR];
  assign ilgl_err = flag_q[`FPSE_F_ILGL];
  assign seq_err = flag_q[`FPSE_F_SEQERR];
  assign cmd_lk = flag_q[`FPSE_F_COMMAND_LOCKED];
  assign cav = flag_q[`FPSE_F_CAV];

  // assembled register images
  wire [7:0] acc_stat;
  wire [7:0] stat0;
  wire [7:0] stat1;
  assign acc_stat = {cav, 2'b00, cmd_lk, data_violation_i[2], 1'b0,
                     data_violation_i[1:0]};
  assign stat0 = {ready_r, ilgl_err, ers_err, prg_err, sus_rdy, 1'b0,
                  ers_spd, prg_spd};
  assign stat1 = {seq_err, 2'b00, lock_status_r, 4'h0};

  // entry write decode
  wire ent_wr;
  wire key_ok;
  wire ent_enabled;
  wire both_entry;
  assign ent_wr = reg_wr_i & hit_ent;
  assign key_ok = reg_word_i & (reg_wdata_i[15:8] == `FPSE_ENT_KEY);
  assign ent_enabled = ent_wr & key_ok & ready_r;
  assign both_entry = entry_r[`FPSE_ENT_CODE] & entry_r[`FPSE_ENT_DATA];

  // error events that force the command lock, and the 10h clear that drops it
  wire prg_err_set;
  wire ers_err_set;
  wire ilgl_set;
  wire acc_clear_ok;
  assign prg_err_set = prog_fail_i | prog_locked_area_i;
  assign ers_err_set = erase_fail_i | erase_locked_area_i;
  // any violation flag or a bad entry setting counts as illegal
  assign ilgl_set = illegal_cmd_i | cav | (|data_violation_i) |
                    both_entry;
  assign acc_clear_ok = status_clear_cmd_i &
                        (acc_stat == `FPSE_ACC_LOCK_ONLY);

  // lock is forced by a fresh error event; a violation still standing
  // keeps forcing it, so one clear at 10h is enough after a plain error
  wire lock_set;
  assign lock_set = prg_err_set | ers_err_set | ilgl_set;

  // violation flag clear: write 0 only after it was read as 1
  wire cav_clear;
  assign cav_clear = reg_wr_i & hit_acc & cav_armed_r &
                     ~reg_wdata_i[`FPSE_ACC_CAV];

  // set and clear terms per flag
  always @* begin
    flag_set = {`FPSE_NFLAG{1'b0}};
    flag_clr = {`FPSE_NFLAG{1'b0}};
    flag_set[`FPSE_F_PROGRAM_SUSPENDED] = prog_suspend_start_i;
    flag_clr[`FPSE_F_PROGRAM_SUSPENDED] = resume_accept_i;
    flag_set[`FPSE_F_ERASE_SUSPENDED] = erase_suspend_start_i;
    flag_clr[`FPSE_F_ERASE_SUSPENDED] = resume_accept_i;
    // entering the lock drops suspend ready in that same cycle
    flag_set[`FPSE_F_SUSPEND_READY] = suspend_point_i & ~cmd_lk & ~lock_set;
    flag_clr[`FPSE_F_SUSPEND_READY] = suspend_accept_i | cmd_lk | lock_set;
    flag_set[`FPSE_F_PROGRAM_ERROR] = prg_err_set;
    flag_clr[`FPSE_F_PROGRAM_ERROR] = status_clear_cmd_i;
    flag_set[`FPSE_F_ERASE_ERROR] = ers_err_set;
    flag_clr[`FPSE_F_ERASE_ERROR] = status_clear_cmd_i;
    flag_set[`FPSE_F_ILGL] = ilgl_set;
    flag_clr[`FPSE_F_ILGL] = acc_clear_ok;
    flag_set[`FPSE_F_SEQERR] = internal_error_i;
    // lock follows from any of the three error sources
    flag_set[`FPSE_F_COMMAND_LOCKED] = lock_set;
    flag_clr[`FPSE_F_COMMAND_LOCKED] = acc_clear_ok;
    flag_set[`FPSE_F_CAV] = code_violation_i;
    flag_clr[`FPSE_F_CAV] = cav_clear;
  end

  // one sticky cell per flag, all initialised by the soft reset
  genvar gi;
  generate
    for (gi = 0; gi < `FPSE_NFLAG; gi = gi + 1) begin : g_flag
      fpse_flag u_flag (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .init_i(seq_soft_reset_i),
        .set_i(flag_set[gi]),
        .clr_i(flag_clr[gi]),
        .flag_o(flag_q[gi])
      );
    end
  endgenerate

  // read-one arming for the violation flag; a fresh event rearms via read
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cav_armed_r <= 1'b0;
    end else if (seq_soft_reset_i) begin
      cav_armed_r <= 1'b0;
    end else if (reg_rd_i & hit_acc & cav) begin
      cav_armed_r <= 1'b1;
    end else if (cav_clear | ~cav) begin
      cav_armed_r <= 1'b0;
    end
  end

  // interrupt enable registers; reserved bits stay zero
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_err_ie_r <= `FPSE_AIE_RESET;
      rdy_ie_r <= `FPSE_RIE_RESET;
    end else begin
      if (reg_wr_i & hit_aie) begin
        acc_err_ie_r <= reg_wdata_i[7:0] & `FPSE_AIE_MASK;
      end
      if (reg_wr_i & hit_rie) begin
        rdy_ie_r <= {7'h00, reg_wdata_i[`FPSE_RIE_EN]};
      end
    end
  end

  // ready tracks the sequencer's busy level one cycle late
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_r <= 1'b1;
    end else if (seq_soft_reset_i) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= ~seq_busy_i;
    end
  end

  // lock bit captured when the read-two command completes
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_status_r <= 1'b0;
    end else if (seq_soft_reset_i) begin
      lock_status_r <= 1'b0;
    end else if (lock_read_done_i) begin
      lock_status_r <= lock_bit_i;
    end
  end

  // next value of the mode-entry register; key bits never stored
  always @* begin
    entry_nxt = entry_r;
    if (ent_wr) begin
      if (!key_ok) begin
        entry_nxt = `FPSE_ENT_RESET;
      end else if (!ent_enabled) begin
        entry_nxt = entry_r;
      end else if (entry_r != `FPSE_ENT_RESET) begin
        entry_nxt = `FPSE_ENT_RESET;
      end else begin
        // from all zero the written bits are taken, zero clears
        entry_nxt = 16'h0000;
        entry_nxt[`FPSE_ENT_CODE] = reg_wdata_i[`FPSE_ENT_CODE];
        entry_nxt[`FPSE_ENT_DATA] = reg_wdata_i[`FPSE_ENT_DATA];
      end
    end
  end

  // mode-entry register
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      entry_r <= `FPSE_ENT_RESET;
    end else if (seq_soft_reset_i) begin
      entry_r <= `FPSE_ENT_RESET;
    end else begin
      entry_r <= entry_nxt;
    end
  end

  // read data stands in the cycle after the read strobe only
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (hit_acc) begin
      reg_rdata_o <= {8'h00, acc_stat};
    end else if (hit_aie) begin
      reg_rdata_o <= {8'h00, acc_err_ie_r};
    end else if (hit_rie) begin
      reg_rdata_o <= {8'h00, rdy_ie_r};
    end else if (hit_s0) begin
      reg_rdata_o <= {8'h00, stat0};
    end else if (hit_s1) begin
      reg_rdata_o <= {8'h00, stat1};
    end else if (hit_ent) begin
      reg_rdata_o <= entry_r; // key reads as zero
    end else begin
      reg_rdata_o <= 16'h0000; // unmapped
    end
  end

  // ready rise detect from the registered ready bit
  wire ready_rise;
  reg ready_d_r;
  assign ready_rise = ready_r & ~ready_d_r;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_d_r <= 1'b1;
    end else begin
      ready_d_r <= ready_r;
    end
  end

  // interrupt requests: access error is a level, ready is a pulse
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      access_error_irq_o <= 1'b0;
      ready_irq_o <= 1'b0;
    end else begin
      access_error_irq_o <= (cmd_lk & acc_err_ie_r[`FPSE_AIE_COMMAND_LOCKED]) |
                            (cav & acc_err_ie_r[`FPSE_AIE_CAV]);
      ready_irq_o <= ready_rise & rdy_ie_r[`FPSE_RIE_EN];
    end
  end

  // array mode and command acceptance; outputs lag the register one cycle
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_accept_ok_o <= 1'b0;
      code_pe_entry_o <= 1'b0;
      data_pe_entry_o <= 1'b0;
      code_window_base_o <= `FPSE_CODE_READ_BASE;
    end else begin
      cmd_accept_ok_o <= (entry_r[`FPSE_ENT_CODE] ^
                          entry_r[`FPSE_ENT_DATA]) & ~cmd_lk;
      code_pe_entry_o <= entry_r[`FPSE_ENT_CODE];
      data_pe_entry_o <= entry_r[`FPSE_ENT_DATA];
      code_window_base_o <= entry_r[`FPSE_ENT_CODE] ?
                            `FPSE_CODE_PE_BASE :
                            `FPSE_CODE_READ_BASE;
    end
  end

endmodule // fpse_top

`default_nettype wire

/* core/fpse_defines.vh */
// constants for the flash program/erase status and mode-entry block
`ifndef FPSE_DEFINES_VH
`define FPSE_DEFINES_VH

// register byte addresses
`define FPSE_ADDR_W 24
`define FPSE_OFF_ACC_STAT 24'h7fc410
`define FPSE_OFF_ACC_ERR_IE 24'h7fc411
`define FPSE_OFF_RDY_IE 24'h7fc412
`define FPSE_OFF_STAT0 24'h7fffb0
`define FPSE_OFF_STAT1 24'h7fffb1
`define FPSE_OFF_ENTRY 24'h7fffb2

// access status register fields
`define FPSE_ACC_CAV 7
`define FPSE_ACC_COMMAND_LOCKED 4
`define FPSE_ACC_LOCK_ONLY 8'h10

// access error interrupt enable fields
`define FPSE_AIE_CAV 7
`define FPSE_AIE_COMMAND_LOCKED 4
`define FPSE_AIE_RESET 8'h9b
`define FPSE_AIE_MASK 8'h9b

// ready interrupt enable fields
`define FPSE_RIE_EN 0
`define FPSE_RIE_RESET 8'h00

// status zero fields
`define FPSE_S0_PROGRAM_SUSPENDED 0
`define FPSE_S0_ERASE_SUSPENDED 1
`define FPSE_S0_SUSPEND_READY 3
`define FPSE_S0_PROGRAM_ERROR 4
`define FPSE_S0_ERASE_ERROR 5
`define FPSE_S0_ILGL 6
`define FPSE_S0_READY 7
`define FPSE_S0_RESET 8'h80

// status one fields
`define FPSE_S1_LOCKST 4
`define FPSE_S1_SEQERR 7
`define FPSE_S1_RESET 8'h00

// mode-entry register fields
`define FPSE_ENT_CODE 0
`define FPSE_ENT_DATA 7
`define FPSE_ENT_KEY 8'haa
`define FPSE_ENT_RESET 16'h0000

// code array windows for the largest capacity
`define FPSE_CODE_READ_BASE 32'hfffc0000
`define FPSE_CODE_PE_BASE 32'h00fc0000

// flag vector indices
`define FPSE_NFLAG 9
`define FPSE_F_PROGRAM_SUSPENDED 0
`define FPSE_F_ERASE_SUSPENDED 1
`define FPSE_F_SUSPEND_READY 2
`define FPSE_F_PROGRAM_ERROR 3
`define FPSE_F_ERASE_ERROR 4
`define FPSE_F_ILGL 5
`define FPSE_F_SEQERR 6
`define FPSE_F_COMMAND_LOCKED 7
`define FPSE_F_CAV 8

`endif

/* core/fpse_flag.v */
// one sticky status flag with set-over-clear and soft initialisation
`timescale 1ns/1ps
`default_nettype none

module fpse_flag (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire init_i,
  input wire set_i,
  input wire clr_i,
  output reg flag_o
);

  // soft init first, then set beats clear so no event is lost
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_o <= 1'b0;
    end else if (init_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

endmodule // fpse_flag

`default_nettype wire

/* verif/fpse_monitor.sv */
// assertion checker for the flash status and mode-entry block
`timescale 1ns/1ps
`default_nettype none
`include "fpse_defines.vh"
module fpse_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_word_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic seq_soft_reset_i,
  input wire logic seq_busy_i,
  input wire logic prog_fail_i,
  input wire logic access_error_irq_o,
  input wire logic ready_irq_o,
  input wire logic cmd_accept_ok_o,
  input wire logic code_pe_entry_o,
  input wire logic data_pe_entry_o,
  input wire logic [31:0] code_window_base_o
);
  logic [7:0] ie_r;
  logic ent_wr;
  // shadow of the error enables; soft reset leaves them alone
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ie_r <= `FPSE_AIE_RESET;
    end else if (reg_wr_i && reg_addr_i == `FPSE_OFF_ACC_ERR_IE) begin
      ie_r <= reg_wdata_i[7:0];
    end
  end
  assign ent_wr = reg_wr_i && reg_addr_i == `FPSE_OFF_ENTRY;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_rdy_irq_edge: assert property (ready_irq_o |->
    $past(seq_busy_i, 3) && !$past(seq_busy_i, 2))
    else $error("ready irq without busy falling");
  chk_rdy_irq_pulse: assert property (ready_irq_o |=> !ready_irq_o)
    else $error("ready irq longer than one cycle");
  chk_window_sel: assert property (code_window_base_o ==
    (code_pe_entry_o ? `FPSE_CODE_PE_BASE : `FPSE_CODE_READ_BASE))
    else $error("window base does not follow entry");
  chk_accept_one: assert property (cmd_accept_ok_o |->
    code_pe_entry_o ^ data_pe_entry_o)
    else $error("commands accepted without one entry bit");
  chk_entry_clear: assert property (ent_wr &&
    (!reg_word_i || reg_wdata_i[15:8] != `FPSE_ENT_KEY)
    |-> ##2 !code_pe_entry_o && !data_pe_entry_o)
    else $error("entry kept after byte or bad key write");
  chk_rdata_zero: assert property (!reg_rd_i || !(reg_addr_i inside
    {24'h7fc410, 24'h7fc411, 24'h7fc412, 24'h7fffb0, 24'h7fffb1,
    24'h7fffb2}) |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero");
  chk_lock_irq: assert property (prog_fail_i && ie_r[4] |->
    ##2 access_error_irq_o)
    else $error("no access error irq after program fail");
  chk_soft_init: assert property (seq_soft_reset_i |->
    ##2 !code_pe_entry_o && !data_pe_entry_o)
    else $error("entry kept over soft reset");
  chk_entry_set: assert property (ent_wr && reg_word_i &&
    reg_wdata_i == 16'haa01 && !code_pe_entry_o && !data_pe_entry_o &&
    !$past(reg_wr_i) && !$past(seq_busy_i) && !seq_soft_reset_i
    |-> ##2 code_pe_entry_o && cmd_accept_ok_o)
    else $error("keyed write from zero did not enter");
  cov_rdy_irq: cover property (ready_irq_o);
  cov_err_irq: cover property (access_error_irq_o);
  cov_entered: cover property (code_pe_entry_o && cmd_accept_ok_o);
endmodule // fpse_monitor
bind fpse_top fpse_monitor mon_u (
  .clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_word_i(reg_word_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .seq_soft_reset_i(seq_soft_reset_i),
  .seq_busy_i(seq_busy_i),
  .prog_fail_i(prog_fail_i),
  .access_error_irq_o(access_error_irq_o),
  .ready_irq_o(ready_irq_o),
  .cmd_accept_ok_o(cmd_accept_ok_o),
  .code_pe_entry_o(code_pe_entry_o),
  .data_pe_entry_o(data_pe_entry_o),
  .code_window_base_o(code_window_base_o)
);
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the flash status and mode-entry block
`timescale 1ns/1ps
`default_nettype none
`include "fpse_defines.vh"
module tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [23:0] addr = 24'h0;
  logic [15:0] wdat = 16'h0;
  logic word = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic busy = 1'b0;
  logic lbit = 1'b0;
  logic [2:0] dviol = 3'h0;
  logic [14:0] ev = 15'h0;
  wire [15:0] rdat;
  wire aeirq, rirq, acc_ok, cent, dent;
  wire [31:0] base;
  int bad_count = 0;
  int compares = 0;
  // event codes: 4 point 5 accept 1/2 suspend 3 resume, then errors
  int evs[17] = '{4, 6, 11, 4, 5, 1, 3, 2, 3, 7, 11, 8, 11, 9, 11, 10, 11};
  logic [7:0] s0e[17] = '{8'h88, 8'h90, 8'h80, 8'h88, 8'h80, 8'h81,
    8'h80, 8'h82, 8'h80, 8'h90, 8'h80, 8'ha0, 8'h80, 8'ha0, 8'h80,
    8'hc0, 8'h80};
  fpse_top dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_word_i(word),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .seq_soft_reset_i(ev[0]), .seq_busy_i(busy),
    .prog_suspend_start_i(ev[1]), .erase_suspend_start_i(ev[2]),
    .resume_accept_i(ev[3]), .suspend_point_i(ev[4]),
    .suspend_accept_i(ev[5]), .prog_fail_i(ev[6]),
    .prog_locked_area_i(ev[7]), .erase_fail_i(ev[8]),
    .erase_locked_area_i(ev[9]), .illegal_cmd_i(ev[10]),
    .status_clear_cmd_i(ev[11]), .code_violation_i(ev[12]),
    .data_violation_i(dviol), .lock_read_done_i(ev[13]),
    .lock_bit_i(lbit), .internal_error_i(ev[14]),
    .access_error_irq_o(aeirq), .ready_irq_o(rirq),
    .cmd_accept_ok_o(acc_ok), .code_pe_entry_o(cent),
    .data_pe_entry_o(dent), .code_window_base_o(base));
  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr_t(input logic [23:0] a, input logic [15:0] d,
    input logic w);
    addr <= a;
    wdat <= d;
    word <= w;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_t(input logic [23:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    chk("rdata", {16'h0, rdat}, {16'h0, e});
    @(posedge clk_sys_i);
  endtask
  task automatic pulse(input int i);
    ev <= 15'h1 << i;
    @(posedge clk_sys_i);
    ev <= 15'h0;
  endtask
  task automatic w2;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic t_reset;
    rd_t(`FPSE_OFF_STAT0, 16'h0080);
    rd_t(`FPSE_OFF_STAT1, 16'h0000);
    rd_t(`FPSE_OFF_ACC_ERR_IE, 16'h009b);
    rd_t(`FPSE_OFF_RDY_IE, 16'h0000);
    rd_t(`FPSE_OFF_ENTRY, 16'h0000);
    rd_t(24'h7fffb3, 16'h0000);
    chk("base", base, `FPSE_CODE_READ_BASE);
  endtask
  task automatic t_entry;
    wr_t(`FPSE_OFF_ENTRY, 16'haa01, 1'b1);
    rd_t(`FPSE_OFF_ENTRY, 16'h0001);
    chk("pe base", base, `FPSE_CODE_PE_BASE);
    chk("code entry", {31'h0, cent}, 32'h1);
    chk("accept", {31'h0, acc_ok}, 32'h1);
    wr_t(`FPSE_OFF_ENTRY, 16'haa80, 1'b1);
    rd_t(`FPSE_OFF_ENTRY, 16'h0000);
    wr_t(`FPSE_OFF_ENTRY, 16'haa01, 1'b1);
    // one idle edge so the strobe is never driven twice in a time step
    @(posedge clk_sys_i);
    wr_t(`FPSE_OFF_ENTRY, 16'haa01, 1'b0);
    rd_t(`FPSE_OFF_ENTRY, 16'h0000);
    wr_t(`FPSE_OFF_ENTRY, 16'haa01, 1'b1);
    @(posedge clk_sys_i);
    wr_t(`FPSE_OFF_ENTRY, 16'hbb01, 1'b1);
    rd_t(`FPSE_OFF_ENTRY, 16'h0000);
    busy <= 1'b1;
    @(posedge clk_sys_i);
    wr_t(`FPSE_OFF_ENTRY, 16'haa01, 1'b1);
    busy <= 1'b0;
    rd_t(`FPSE_OFF_ENTRY, 16'h0000);
    wr_t(`FPSE_OFF_ENTRY, 16'haa81, 1'b1);
    // illegal follows the stored entry value one edge later
    @(posedge clk_sys_i);
    rd_t(`FPSE_OFF_STAT0, 16'h00c0);
    chk("accept", {31'h0, acc_ok}, 32'h0);
    chk("data entry", {31'h0, dent}, 32'h1);
    wr_t(`FPSE_OFF_ENTRY, 16'h0000, 1'b0);
    pulse(11);
    rd_t(`FPSE_OFF_STAT0, 16'h0080);
  endtask
  task automatic t_status;
    foreach (evs[i]) begin
      pulse(evs[i]);
      rd_t(`FPSE_OFF_STAT0, {8'h00, s0e[i]});
    end
  endtask
  task automatic t_irq;
    pulse(6);
    w2;
    chk("ae irq", {31'h0, aeirq}, 32'h1);
    @(posedge clk_sys_i);
    pulse(11);
    wr_t(`FPSE_OFF_ACC_ERR_IE, 16'h0000, 1'b0);
    pulse(6);
    w2;
    chk("ae irq", {31'h0, aeirq}, 32'h0);
    @(posedge clk_sys_i);
    pulse(11);
    @(posedge clk_sys_i);
    pulse(12);
    w2;
    chk("ae irq", {31'h0, aeirq}, 32'h0);
    @(posedge clk_sys_i);
    wr_t(`FPSE_OFF_ACC_ERR_IE, 16'h0080, 1'b0);
    w2;
    chk("ae irq", {31'h0, aeirq}, 32'h1);
    @(posedge clk_sys_i);
    // a zero written before any read of one must not clear
    wr_t(`FPSE_OFF_ACC_STAT, 16'h0000, 1'b0);
    rd_t(`FPSE_OFF_ACC_STAT, 16'h0090);
    wr_t(`FPSE_OFF_ACC_STAT, 16'h0000, 1'b0);
    rd_t(`FPSE_OFF_ACC_STAT, 16'h0010);
    pulse(11);
    rd_t(`FPSE_OFF_STAT0, 16'h0080);
    wr_t(`FPSE_OFF_ACC_ERR_IE, 16'h009b, 1'b0);
  endtask
  task automatic t_lock;
    // a data-side violation level alone raises illegal and the lock
    dviol <= 3'h1;
    rd_t(`FPSE_OFF_ACC_STAT, 16'h0001);
    rd_t(`FPSE_OFF_STAT0, 16'h00c0);
    dviol <= 3'h0;
    pulse(11);
    rd_t(`FPSE_OFF_STAT0, 16'h0080);
    lbit <= 1'b1;
    pulse(13);
    rd_t(`FPSE_OFF_STAT1, 16'h0010);
    lbit <= 1'b0;
    rd_t(`FPSE_OFF_STAT1, 16'h0010);
    pulse(13);
    rd_t(`FPSE_OFF_STAT1, 16'h0000);
  endtask
  task automatic t_soft;
    wr_t(`FPSE_OFF_ENTRY, 16'haa01, 1'b1);
    pulse(14);
    rd_t(`FPSE_OFF_STAT1, 16'h0080);
    pulse(0);
    rd_t(`FPSE_OFF_STAT1, 16'h0000);
    rd_t(`FPSE_OFF_ENTRY, 16'h0000);
  endtask
  task automatic t_ready(input logic en);
    logic got;
    got = 1'b0;
    wr_t(`FPSE_OFF_RDY_IE, {15'h0, en}, 1'b0);
    busy <= 1'b1;
    @(posedge clk_sys_i);
    rd_t(`FPSE_OFF_STAT0, 16'h0000);
    busy <= 1'b0;
    repeat (4) begin
      @(posedge clk_sys_i);
      #1;
      if (rirq === 1'b1) got = 1'b1;
    end
    chk("rdy irq", {31'h0, got}, {31'h0, en});
    @(posedge clk_sys_i);
    rd_t(`FPSE_OFF_STAT0, 16'h0080);
  endtask
  task automatic report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog well beyond the fewer than two hundred cycles the run needs
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset;
    t_entry;
    t_status;
    t_irq;
    t_lock;
    t_soft;
    t_ready(1'b1);
    t_ready(1'b0);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
